//--- logic/isp_pkg.sv
// Constants shared by the interrupt source prioritizer
package isp_pkg;
    localparam int          ISP_NUM_LINES     = 6;
    localparam int          ISP_LVL_W         = 3;
    localparam int          ISP_VEC_W         = 8;
    localparam int          ISP_ADDR_W        = 16;
    // Vector numbers of fixed sources
    localparam logic [7:0]  ISP_VEC_NMI       = 8'h07;
    localparam logic [7:0]  ISP_VEC_LINE0     = 8'h10;
    localparam logic [15:0] ISP_ADDR_NMI      = 16'h001c;
    localparam logic [15:0] ISP_ADDR_LINE0    = 16'h0040;
    // Sense field encodings and reset value
    localparam logic [1:0]  ISP_SENSE_LOW     = 2'h0;
    localparam logic [1:0]  ISP_SENSE_FALL    = 2'h1;
    localparam logic [1:0]  ISP_SENSE_RISE    = 2'h2;
    localparam logic [1:0]  ISP_SENSE_BOTH    = 2'h3;
    localparam logic [11:0] ISP_SENSE_RST     = 12'h000;
    localparam logic [5:0]  ISP_STATUS_RST    = 6'h00;
    localparam logic [1:0]  ISP_SYNC_RST      = 2'h3;
    localparam logic [2:0]  ISP_LVL_NONE      = 3'h0;
endpackage

//--- logic/isp_prioritizer.sv
// Interrupt source prioritizer: detection, flags, priority and vector output
// Overview of operation
// - Seven external inputs, all can wake standby
// - Non-maskable request always wins and forwarded
// - Configuration bit selects non-maskable edge polarity
// - Each line senses low, fall, rise, both
// - Sense codes 00 low 01 fall 10 rise 11 both
// - Disabled lines forward no request
// - Status flags record detection, software clears
// - Clear only after read-one-write-zero or handling
// - Detection independent of pin direction
// - Programmable level per line and peripheral group
// - Peripheral request needs flag and enable
// - Transfer start ignores mode and mask
// - Lower vector number wins by default
// - Equal levels fall back to vector order
// - Non-maskable vector 7, address 001c
// - Lines use vectors 16 to 21 from 0040
`timescale 1ns/1ps
module isp_prioritizer
    import isp_pkg::*;
#(
    parameter int NUM_PERIPH = 4
) (
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rst_b,
    // Pins, sampled on the pad side so pin direction does not matter
    input  wire logic                           nmi_pin,
    input  wire logic [ISP_NUM_LINES-1:0]       ext_request_lines,
    // Configuration
    input  wire logic                           nonmask_edge_select,
    input  wire logic [2*ISP_NUM_LINES-1:0]     sense_control_reg,
    input  wire logic                           sense_we,
    input  wire logic [ISP_NUM_LINES-1:0]       line_enable_reg,
    input  wire logic [ISP_LVL_W*ISP_NUM_LINES-1:0] priority_level_reg,
    // Status flag access: read marks arming, write of zero clears armed flags
    input  wire logic                           status_rd,
    input  wire logic                           status_wr,
    input  wire logic [ISP_NUM_LINES-1:0]       status_wdata,
    // Exception handling acknowledge from the core
    input  wire logic                           ack,
    input  wire logic [ISP_VEC_W-1:0]           ack_vector,
    // On-chip peripheral groups
    input  wire logic [NUM_PERIPH-1:0]          periph_flag,
    input  wire logic [NUM_PERIPH-1:0]          periph_enable,
    input  wire logic [ISP_LVL_W*NUM_PERIPH-1:0] periph_level,
    input  wire logic [ISP_VEC_W*NUM_PERIPH-1:0] periph_vector,
    input  wire logic [NUM_PERIPH-1:0]          periph_xfer_route,
    // Outputs to the core and the transfer controller
    output logic [ISP_NUM_LINES-1:0]            line_status_reg,
    output logic                                irq_valid,
    output logic                                irq_nonmask,
    output logic [ISP_LVL_W-1:0]                irq_level,
    output logic [ISP_VEC_W-1:0]                irq_vector,
    output logic [ISP_ADDR_W-1:0]               irq_vec_addr,
    output logic                                wake_req,
    output logic [NUM_PERIPH-1:0]               xfer_start
);
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_bad_periph
        $error("NUM_PERIPH out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [ISP_NUM_LINES:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
    logic [ISP_NUM_LINES-1:0] lines, prev;
    logic nmi_now, nmi_prev;
    always_comb begin
        s1_d = {nmi_pin, ext_request_lines};
        s2_d = s1_q;
        s3_d = s2_q;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end
    assign lines    = s2_q[ISP_NUM_LINES-1:0];
    assign prev     = s3_q[ISP_NUM_LINES-1:0];
    assign nmi_now  = s2_q[ISP_NUM_LINES];
    assign nmi_prev = s3_q[ISP_NUM_LINES];

    ////////////////////////////////////////////////////////////////////////////////
    // Line detection and status flags
    logic [2*ISP_NUM_LINES-1:0] sense_q, sense_d;
    logic [ISP_NUM_LINES-1:0] flag_q, flag_d, armed_q, armed_d, det;
    logic nmi_pend_q, nmi_pend_d, nmi_det;

    // Sense is held here so a change only takes effect on its write strobe
    generate
        for (genvar i = 0; i < ISP_NUM_LINES; i++) begin : g_det
            always_comb begin
                case (sense_q[2*i +: 2])
                    ISP_SENSE_LOW:  det[i] = !lines[i];
                    ISP_SENSE_FALL: det[i] = prev[i] && !lines[i];
                    ISP_SENSE_RISE: det[i] = !prev[i] && lines[i];
                    default:        det[i] = prev[i] ^ lines[i];
                endcase
            end
        end
    endgenerate

    assign nmi_det = nonmask_edge_select ? (!nmi_prev && nmi_now)
                                         : (nmi_prev && !nmi_now);

    always_comb begin
        sense_d    = sense_we ? sense_control_reg : sense_q;
        flag_d     = flag_q;
        armed_d    = armed_q;
        nmi_pend_d = nmi_pend_q;
        if (status_rd) begin
            armed_d = armed_q | flag_q;
        end
        if (status_wr) begin
            flag_d  = flag_q & (status_wdata | ~armed_q);
            armed_d = armed_d & status_wdata;
        end
        if (ack) begin
            for (int i = 0; i < ISP_NUM_LINES; i++) begin
                if (ack_vector == ISP_VEC_LINE0 + ISP_VEC_W'(i) &&
                    (sense_q[2*i +: 2] != ISP_SENSE_LOW || lines[i])) begin
                    flag_d[i] = 1'b0;
                end
            end
            if (ack_vector == ISP_VEC_NMI) begin
                nmi_pend_d = 1'b0;
            end
        end
        // Detection wins over any clear in the same cycle
        flag_d = flag_d | det;
        if (nmi_det) begin
            nmi_pend_d = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sense_q    <= ISP_SENSE_RST;
            flag_q     <= ISP_STATUS_RST;
            armed_q    <= ISP_STATUS_RST;
            nmi_pend_q <= 1'b0;
        end else begin
            sense_q    <= sense_d;
            flag_q     <= flag_d;
            armed_q    <= armed_d;
            nmi_pend_q <= nmi_pend_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority selection; ascending scan with strict compare keeps the lowest vector
    logic                 v_d, nm_d, wk_d;
    logic [ISP_LVL_W-1:0] lv_d;
    logic [ISP_VEC_W-1:0] vec_d;
    logic [NUM_PERIPH-1:0] xs_d;
    always_comb begin
        v_d   = 1'b0;
        nm_d  = 1'b0;
        lv_d  = ISP_LVL_NONE;
        vec_d = '0;
        for (int i = 0; i < ISP_NUM_LINES; i++) begin
            if (flag_q[i] && line_enable_reg[i] &&
                (!v_d || priority_level_reg[ISP_LVL_W*i +: ISP_LVL_W] > lv_d)) begin
                v_d   = 1'b1;
                lv_d  = priority_level_reg[ISP_LVL_W*i +: ISP_LVL_W];
                vec_d = ISP_VEC_LINE0 + ISP_VEC_W'(i);
            end
        end
        for (int p = 0; p < NUM_PERIPH; p++) begin
            if (periph_flag[p] && periph_enable[p] && !periph_xfer_route[p] &&
                (!v_d || periph_level[ISP_LVL_W*p +: ISP_LVL_W] > lv_d ||
                 (periph_level[ISP_LVL_W*p +: ISP_LVL_W] == lv_d &&
                  periph_vector[ISP_VEC_W*p +: ISP_VEC_W] < vec_d))) begin
                v_d   = 1'b1;
                lv_d  = periph_level[ISP_LVL_W*p +: ISP_LVL_W];
                vec_d = periph_vector[ISP_VEC_W*p +: ISP_VEC_W];
            end
        end
        if (nmi_pend_q) begin
            v_d   = 1'b1;
            nm_d  = 1'b1;
            lv_d  = '1;
            vec_d = ISP_VEC_NMI;
        end
        // Transfer starts bypass the core's mode and mask entirely
        xs_d = periph_flag & periph_enable & periph_xfer_route;
        wk_d = nmi_pend_q || |(flag_q & line_enable_reg);
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_valid    <= 1'b0;
            irq_nonmask  <= 1'b0;
            irq_level    <= ISP_LVL_NONE;
            irq_vector   <= '0;
            irq_vec_addr <= '0;
            wake_req     <= 1'b0;
            xfer_start   <= '0;
            line_status_reg <= ISP_STATUS_RST;
        end else begin
            irq_valid    <= v_d;
            irq_nonmask  <= nm_d;
            irq_level    <= lv_d;
            irq_vector   <= vec_d;
            irq_vec_addr <= {6'h00, vec_d, 2'h0};
            wake_req     <= wk_d;
            xfer_start   <= xs_d;
            line_status_reg <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_nmi_wins;
        @(posedge sys_clk) disable iff (!rst_b)
        nmi_pend_q |=> irq_valid && irq_nonmask && irq_vector == ISP_VEC_NMI;
    endproperty
    a_nmi_wins: assert property (p_nmi_wins) else $error("nmi not presented");

    property p_nmi_addr;
        @(posedge sys_clk) disable iff (!rst_b)
        irq_nonmask |-> irq_vec_addr == ISP_ADDR_NMI;
    endproperty
    a_nmi_addr: assert property (p_nmi_addr) else $error("nmi address wrong");

    property p_addr_x4;
        @(posedge sys_clk) disable iff (!rst_b)
        irq_valid |-> irq_vec_addr == {6'h00, irq_vector, 2'h0};
    endproperty
    a_addr_x4: assert property (p_addr_x4) else $error("vector address mismatch");

    property p_line0_addr;
        @(posedge sys_clk) disable iff (!rst_b)
        irq_valid && irq_vector == ISP_VEC_LINE0 |-> irq_vec_addr == ISP_ADDR_LINE0;
    endproperty
    a_line0_addr: assert property (p_line0_addr) else $error("line 0 address wrong");

    property p_det_sets;
        @(posedge sys_clk) disable iff (!rst_b)
        det[0] |=> line_status_reg[0] && flag_q[0];
    endproperty
    a_det_sets: assert property (p_det_sets) else $error("detection lost");

    property p_no_unarmed_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        flag_q[0] && !armed_q[0] && !ack && !sense_we |=> flag_q[0];
    endproperty
    a_no_unarmed_clear: assert property (p_no_unarmed_clear) else $error("flag cleared");

    property p_disabled_quiet;
        @(posedge sys_clk) disable iff (!rst_b)
        line_enable_reg == '0 && periph_flag == '0 && !nmi_pend_q |=> !irq_valid;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled request");

    property p_xfer;
        @(posedge sys_clk) disable iff (!rst_b)
        periph_flag[0] && periph_enable[0] && periph_xfer_route[0] |=> xfer_start[0];
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer not started");
endmodule

//--- verification/isp_core_model.sv
// Behavioural core that accepts presented requests and acknowledges them
`timescale 1ns/1ps
module isp_core_model
    import isp_pkg::*;
(
    // Clock and acceptance control
    input  wire logic                 sys_clk,
    input  wire logic                 accept,
    // Request from the prioritizer
    input  wire logic                 irq_valid,
    input  wire logic [ISP_VEC_W-1:0] irq_vector,
    // Handling acknowledge
    output logic                      ack = 1'b0,
    output logic [ISP_VEC_W-1:0]      ack_vector = 8'h00
);
    int wait_cnt = 0;
    // Never drives request pins, those come only from the bench
    // Waits three cycles so a stale vector is never acknowledged twice
    always @(posedge sys_clk) begin
        ack <= 1'b0;
        ack_vector <= ~irq_vector;
        if (accept && irq_valid) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == 3) begin
                ack <= 1'b1;
                ack_vector <= irq_vector;
                wait_cnt <= 0;
            end
        end else begin
            // Restart when acceptance or the request drops and after each acknowledge, so a vector change under a steady request keeps the count
            wait_cnt <= 0;
        end
    end
endmodule

//--- verification/isp_prioritizer_bench.sv
// Directed bench for the interrupt source prioritizer
`timescale 1ns/1ps
module isp_prioritizer_bench;
    import isp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        nmi_pin = 1'b1;
    logic [5:0]  ext_request_lines = 6'h3f;
    logic        nonmask_edge_select = 1'b0;
    logic [11:0] sense_control_reg = 12'h000;
    logic        sense_we = 1'b0;
    logic [5:0]  line_enable_reg = 6'h00;
    logic [17:0] priority_level_reg = 18'h00000;
    logic        status_rd = 1'b0;
    logic        status_wr = 1'b0;
    logic [5:0]  status_wdata = 6'h00;
    logic [11:0] periph_level = 12'h000;
    logic        accept = 1'b0;
    logic [3:0]  periph_flag = 4'h0;
    logic [3:0]  periph_enable = 4'h0;
    logic [3:0]  periph_xfer_route = 4'h0;
    logic        ack;
    logic [7:0]  ack_vector;
    logic [5:0]  line_status_reg;
    logic        irq_valid;
    logic        irq_nonmask;
    logic [2:0]  irq_level;
    logic [7:0]  irq_vector;
    logic [15:0] irq_vec_addr;
    logic        wake_req;
    logic [3:0]  xfer_start;
    int          fail_count = 0;
    int          total_checks = 0;

    isp_prioritizer #(.NUM_PERIPH(4)) u_isp_prioritizer (.sys_clk(sys_clk), .rst_b(rst_b),
        .nmi_pin(nmi_pin), .ext_request_lines(ext_request_lines),
        .nonmask_edge_select(nonmask_edge_select), .sense_control_reg(sense_control_reg),
        .sense_we(sense_we), .line_enable_reg(line_enable_reg),
        .priority_level_reg(priority_level_reg), .status_rd(status_rd), .status_wr(status_wr),
        .status_wdata(status_wdata), .ack(ack), .ack_vector(ack_vector),
        .periph_flag(periph_flag), .periph_enable(periph_enable),
        .periph_level(periph_level), .periph_vector(32'h23222120),
        .periph_xfer_route(periph_xfer_route), .line_status_reg(line_status_reg),
        .irq_valid(irq_valid), .irq_nonmask(irq_nonmask), .irq_level(irq_level),
        .irq_vector(irq_vector), .irq_vec_addr(irq_vec_addr), .wake_req(wake_req),
        .xfer_start(xfer_start));
    isp_core_model u_isp_core_model (.sys_clk(sys_clk), .accept(accept),
        .irq_valid(irq_valid), .irq_vector(irq_vector), .ack(ack), .ack_vector(ack_vector));

    ////////////////////////////////////////////////////////////////////////////////
    initial forever #12.5 sys_clk = ~sys_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic pins(input logic [5:0] v);
        @(posedge sys_clk) ext_request_lines <= v;
        tick(6);
    endtask
    // Write with ones kept where asked; arms the flags first only when asked
    task automatic write_zero(input logic arm, input logic [5:0] keep);
        @(posedge sys_clk) status_rd <= arm;
        @(posedge sys_clk) status_rd <= 1'b0;
        status_wdata <= keep;
        status_wr <= 1'b1;
        @(posedge sys_clk) status_wr <= 1'b0;
        tick(4);
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 3000);
        fail_count++;
        close_out();
    end

    initial begin
        @(posedge sys_clk);
        @(posedge sys_clk) rst_b <= 1'b1;
        tick(3);
        chk(16'h0000, {10'h000, line_status_reg});
        chk(16'h0000, {15'h0000, irq_valid});
        // Lines 3..0 low, both, rise, fall; lines 5 and 4 fall
        @(posedge sys_clk) sense_control_reg <= 12'h539;
        sense_we <= 1'b1;
        @(posedge sys_clk) sense_we <= 1'b0;
        pins(6'h36);
        chk(16'h0009, {10'h000, line_status_reg});
        chk(16'h0000, {15'h0000, irq_valid});
        pins(6'h3f);
        pins(6'h39);
        chk(16'h000d, {10'h000, line_status_reg});
        pins(6'h3f);
        chk(16'h000f, {10'h000, line_status_reg});
        write_zero(1'b0, 6'h00);
        chk(16'h000f, {10'h000, line_status_reg});
        write_zero(1'b1, 6'h02);
        chk(16'h0002, {10'h000, line_status_reg});
        write_zero(1'b1, 6'h00);
        chk(16'h0000, {10'h000, line_status_reg});
        // Equal levels, then a raised level on line 5
        @(posedge sys_clk) line_enable_reg <= 6'h3f;
        pins(6'h0f);
        pins(6'h3f);
        chk(16'h0014, {8'h00, irq_vector});
        chk(16'h0050, irq_vec_addr);
        @(posedge sys_clk) priority_level_reg <= 18'h18000;
        tick(4);
        chk(16'h0015, {8'h00, irq_vector});
        chk(16'h0054, irq_vec_addr);
        chk(16'h0003, {13'h0000, irq_level});
        @(posedge sys_clk) accept <= 1'b1;
        tick(20);
        chk(16'h0000, {10'h000, line_status_reg});
        @(posedge sys_clk) accept <= 1'b0;
        pins(6'h2f);
        pins(6'h3f);
        chk(16'h0014, {8'h00, irq_vector});
        // Falling edge ignored when rising is selected
        @(posedge sys_clk) nonmask_edge_select <= 1'b1;
        nmi_pin <= 1'b0;
        tick(6);
        chk(16'h0000, {15'h0000, irq_nonmask});
        @(posedge sys_clk) nmi_pin <= 1'b1;
        tick(6);
        chk(16'h0001, {15'h0000, irq_nonmask});
        chk(16'h0007, {8'h00, irq_vector});
        chk(16'h001c, irq_vec_addr);
        chk(16'h0001, {15'h0000, wake_req});
        @(posedge sys_clk) accept <= 1'b1;
        tick(20);
        chk(16'h0000, {15'h0000, irq_valid});
        // Peripheral sources need flag and enable; routed ones start transfers
        @(posedge sys_clk) accept <= 1'b0;
        periph_flag <= 4'h3;
        periph_enable <= 4'h1;
        tick(5);
        chk(16'h0020, {8'h00, irq_vector});
        @(posedge sys_clk) periph_enable <= 4'h2;
        tick(5);
        chk(16'h0021, {8'h00, irq_vector});
        @(posedge sys_clk) periph_enable <= 4'h3;
        tick(5);
        chk(16'h0020, {8'h00, irq_vector});
        // Group 1 raised to level 2 overtakes the lower vector
        @(posedge sys_clk) periph_level <= 12'h010;
        tick(5);
        chk(16'h0021, {8'h00, irq_vector});
        chk(16'h0002, {13'h0000, irq_level});
        @(posedge sys_clk) periph_xfer_route <= 4'h3;
        tick(5);
        chk(16'h0003, {12'h000, xfer_start});
        chk(16'h0000, {15'h0000, irq_valid});
        close_out();
    end
endmodule
